//--- logic/ams_pkg.sv
/*
  Constants for the two-channel analog monitor select-and-scale block:
  register indices, reset values, setting limits, selection codes and the
  fixed-point factors that turn internal quantities into millivolts and
  millivolts into converter codes.
  Assumes a converter with a signed 16-bit code spanning +/-10 V.
*/
package ams_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices on the plain register port
  localparam logic [3:0] AMS_A_SEL1     = 4'h0;
  localparam logic [3:0] AMS_A_SEL2     = 4'h1;
  localparam logic [3:0] AMS_A_OFF1     = 4'h2;
  localparam logic [3:0] AMS_A_OFF2     = 4'h3;
  localparam logic [3:0] AMS_A_MAG1     = 4'h4;
  localparam logic [3:0] AMS_A_MAG2     = 4'h5;
  localparam logic [3:0] AMS_A_TRQ_TOFF = 4'h6;
  localparam logic [3:0] AMS_A_TRQ_TGN  = 4'h7;
  localparam logic [3:0] AMS_A_SPD_TOFF = 4'h8;
  localparam logic [3:0] AMS_A_SPD_TGN  = 4'h9;
  localparam logic [3:0] AMS_A_CTRL     = 4'hA;
  localparam logic [3:0] AMS_A_CODE1    = 4'hB;
  localparam logic [3:0] AMS_A_CODE2    = 4'hC;

  // Control register: writing this bit restores the parameter defaults
  localparam int AMS_CTRL_INIT_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [15:0] AMS_SEL1_RST = 16'h0002;
  localparam logic [15:0] AMS_SEL2_RST = 16'h0000;
  localparam logic [15:0] AMS_OFF_RST  = 16'h0000;
  localparam logic [15:0] AMS_MAG_RST  = 16'h0064;
  localparam logic [15:0] AMS_TRIM_RST = 16'h0000;

  // Setting limits, symmetric about zero
  localparam logic signed [15:0] AMS_PARAM_LIM = 16'sh2710;
  localparam logic signed [15:0] AMS_TOFF_LIM  = 16'sh007F;
  localparam logic signed [15:0] AMS_TGN_LIM   = 16'sh007D;

  ////////////////////////////////////////////////////////////////////////////
  // Selection codes (low two hex digits of the selection register)
  localparam logic [7:0] AMS_SEL_MOTOR_SPD = 8'h00;
  localparam logic [7:0] AMS_SEL_SPD_REF   = 8'h01;
  localparam logic [7:0] AMS_SEL_TRQ_REF   = 8'h02;
  localparam logic [7:0] AMS_SEL_POS_DEV   = 8'h03;
  localparam logic [7:0] AMS_SEL_AMP_DEV   = 8'h04;
  localparam logic [7:0] AMS_SEL_CMD_SPD   = 8'h05;
  localparam logic [7:0] AMS_SEL_RESERVED  = 8'h06;
  localparam logic [7:0] AMS_SEL_LOAD_DEV  = 8'h07;
  localparam logic [7:0] AMS_SEL_POS_DONE  = 8'h08;
  localparam logic [7:0] AMS_SEL_SPD_FF    = 8'h09;
  localparam logic [7:0] AMS_SEL_TRQ_FF    = 8'h0A;
  localparam logic [7:0] AMS_SEL_GAIN      = 8'h0B;
  localparam logic [7:0] AMS_SEL_DIST_DONE = 8'h0C;
  localparam logic [7:0] AMS_SEL_EXT_SPD   = 8'h0D;
  localparam logic [7:0] AMS_SEL_DC_BUS    = 8'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Millivolt factors per input unit
  localparam logic signed [63:0] AMS_MV_DEV      = 64'sh0000_0000_0000_0032;
  localparam logic signed [63:0] AMS_MV_LOAD_DEV = 64'sh0000_0000_0000_000A;
  localparam logic signed [63:0] AMS_MV_DC_BUS   = 64'sh0000_0000_0000_000A;
  localparam logic signed [63:0] AMS_MV_FLAG     = 64'sh0000_0000_0000_1388;
  localparam logic signed [63:0] AMS_MV_GAIN1    = 64'sh0000_0000_0000_03E8;
  localparam logic signed [63:0] AMS_MV_GAIN2    = 64'sh0000_0000_0000_07D0;
  localparam logic signed [63:0] AMS_MV_OFF_STEP = 64'sh0000_0000_0000_0064;
  localparam logic signed [63:0] AMS_MAG_UNITY   = 64'sh0000_0000_0000_0064;
  // Trim: offset 18.9 mV per step, gain 0.4 % per step = 1/250
  localparam logic signed [63:0] AMS_TOFF_NUM    = 64'sh0000_0000_0000_00BD;
  localparam logic signed [63:0] AMS_TOFF_DEN    = 64'sh0000_0000_0000_000A;
  localparam logic signed [63:0] AMS_TGN_BASE    = 64'sh0000_0000_0000_00FA;
  // Code per millivolt = 32768/10000, held as 13422/4096
  localparam logic signed [63:0] AMS_CODE_NUM    = 64'sh0000_0000_0000_346E;
  localparam int                 AMS_CODE_SHIFT  = 12;
  localparam logic signed [63:0] AMS_CODE_MAX    = 64'sh0000_0000_0000_7FFF;
  localparam logic signed [63:0] AMS_CODE_MIN    = -64'sh0000_0000_0000_8000;

endpackage : ams_pkg

//--- logic/ams_monitor.sv
/*
  Two-channel analog monitor: selects an internal quantity per channel,
  applies factory trims, magnification and offset, negates, saturates and
  loads a signed 16-bit converter code once per control cycle.
  Assumes the drive control logic supplies ctrl_tick_i once per control
  cycle and all monitored quantities synchronous to clk_i; speeds in
  min^-1 or mm/s, torques in 0.1 % rated, deviations in their own units,
  DC bus in volts.
*/
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1 - Two channels, each sourced by low two hex digits of its selection.
// R2 - Code 00 motor speed, 1 V per 1000 units; channel two default.
// R3 - Codes 01, 05, 09 speeds use same 1 V per 1000 scaling.
// R4 - Codes 02, 0A torque at 1 V per 100 %; channel one default.
// R5 - Code 03 at 0.05 V per reference unit, 04 per encoder pulse.
// R6 - Code 07 motor-load deviation at 0.01 V per reference unit.
// R7 - Code 08 gives 5 V when positioning completed, else 0 V.
// R8 - Code 0C gives 5 V when distribution completed, else 0 V.
// R9 - Code 0B gives 1 V for first gain, 2 V for second.
// R10 - Code 0D external encoder speed at 1 V per 1000 min^-1.
// R11 - Code 10 DC bus voltage at 1 V per 100 V.
// R12 - Software never programs reserved code 06 into a channel.
// R13 - Output is minus the sum of signal times magnification plus offset.
// R14 - Offset range +/-10000 in 0.1 V, default 0, immediate.
// R15 - Magnification range +/-10000 in 0.01, default 100, immediate.
// R16 - Converter code is 16 bits; linear only within +/-8 V.
// R17 - Factory offset and gain trims apply to torque and speed monitors; only codes 02 and 00 are trimmed, not 01, 05, 09, 0A or 0D.
// R18 - Offset trim 18.9 mV steps to 2.4 V, gain trim 0.4 % steps.
// R19 - Parameter initialisation leaves the trim values untouched.
// R20 - Out-of-range results saturate at the nearest full-scale code.
// R21 - Each code is recomputed once per control cycle from current settings.
module ams_monitor #(
  parameter int QW = 32                          // Width of monitored quantities
) (
  input  wire logic                 clk_i,           // 50 MHz clock
  input  wire logic                 reset_n_i,       // Async reset, active low
  input  wire logic [3:0]           reg_addr_i,      // Register index
  input  wire logic [15:0]          reg_wdata_i,     // Write data
  input  wire logic                 reg_we_i,        // Write strobe
  input  wire logic                 reg_re_i,        // Read strobe
  output var  logic [15:0]          reg_rdata_o,     // Read data, cycle after strobe
  input  wire logic                 ctrl_tick_i,     // Control cycle pulse
  input  wire logic signed [QW-1:0] motor_speed_i,   // Motor speed
  input  wire logic signed [QW-1:0] speed_ref_i,     // Speed reference
  input  wire logic signed [QW-1:0] cmd_speed_i,     // Position command speed
  input  wire logic signed [QW-1:0] speed_ff_i,      // Speed feedforward
  input  wire logic signed [QW-1:0] ext_speed_i,     // External encoder speed
  input  wire logic signed [QW-1:0] torque_ref_i,    // Torque reference
  input  wire logic signed [QW-1:0] torque_ff_i,     // Torque feedforward
  input  wire logic signed [QW-1:0] pos_dev_i,       // Position deviation
  input  wire logic signed [QW-1:0] amp_dev_i,       // Deviation after gear
  input  wire logic signed [QW-1:0] load_dev_i,      // Motor-load deviation
  input  wire logic signed [QW-1:0] dc_bus_i,        // DC bus volts
  input  wire logic                 pos_done_i,      // Positioning completed
  input  wire logic                 dist_done_i,     // Distribution completed
  input  wire logic                 gain2_active_i,  // Second gain set active
  output var  logic [15:0]          dac_ch1_o,       // Channel one code
  output var  logic [15:0]          dac_ch2_o,       // Channel two code
  output var  logic                 dac_load_o       // Codes updated pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [15:0] ams_clamp(input logic [15:0] v,
                                            input logic signed [15:0] lim);
    logic signed [15:0] s;
    s = signed'(v);
    if (s > lim) begin
      return lim;
    end else if (s < -lim) begin
      return -lim;
    end
    return v;
  endfunction : ams_clamp

  function automatic logic [15:0] ams_mv2code(input logic signed [63:0] mv);
    logic signed [63:0] c;
    c = (mv * ams_pkg::AMS_CODE_NUM) >>> ams_pkg::AMS_CODE_SHIFT;
    if (c > ams_pkg::AMS_CODE_MAX) begin
      return 16'h7FFF;
    end else if (c < ams_pkg::AMS_CODE_MIN) begin
      return 16'h8000;
    end
    return c[15:0];
  endfunction : ams_mv2code

  ////////////////////////////////////////////////////////////////////////////
  // Parameters and trims

  logic [15:0] sel_reg  [2];
  logic [15:0] off_reg  [2];
  logic [15:0] mag_reg  [2];
  logic [15:0] trq_toff_reg;
  logic [15:0] trq_tgn_reg;
  logic [15:0] spd_toff_reg;
  logic [15:0] spd_tgn_reg;
  logic [15:0] code_reg [2];
  logic        init_w;

  assign init_w = reg_we_i && (reg_addr_i == ams_pkg::AMS_A_CTRL)
                  && reg_wdata_i[ams_pkg::AMS_CTRL_INIT_BIT];

  // Writes land at once and are used from the next control cycle on
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sel_reg[0] <= ams_pkg::AMS_SEL1_RST;                    // see R4
      sel_reg[1] <= ams_pkg::AMS_SEL2_RST;                    // see R2
      off_reg[0] <= ams_pkg::AMS_OFF_RST;
      off_reg[1] <= ams_pkg::AMS_OFF_RST;
      mag_reg[0] <= ams_pkg::AMS_MAG_RST;
      mag_reg[1] <= ams_pkg::AMS_MAG_RST;
    end else if (init_w) begin
      sel_reg[0] <= ams_pkg::AMS_SEL1_RST;
      sel_reg[1] <= ams_pkg::AMS_SEL2_RST;
      off_reg[0] <= ams_pkg::AMS_OFF_RST;                     // see R14
      off_reg[1] <= ams_pkg::AMS_OFF_RST;
      mag_reg[0] <= ams_pkg::AMS_MAG_RST;                     // see R15
      mag_reg[1] <= ams_pkg::AMS_MAG_RST;
    end else if (reg_we_i) begin
      case (reg_addr_i)
        ams_pkg::AMS_A_SEL1: sel_reg[0] <= reg_wdata_i;       // see R1
        ams_pkg::AMS_A_SEL2: sel_reg[1] <= reg_wdata_i;       // see R1
        ams_pkg::AMS_A_OFF1: off_reg[0] <= ams_clamp(reg_wdata_i, ams_pkg::AMS_PARAM_LIM); // see R14
        ams_pkg::AMS_A_OFF2: off_reg[1] <= ams_clamp(reg_wdata_i, ams_pkg::AMS_PARAM_LIM); // see R14
        ams_pkg::AMS_A_MAG1: mag_reg[0] <= ams_clamp(reg_wdata_i, ams_pkg::AMS_PARAM_LIM); // see R15
        ams_pkg::AMS_A_MAG2: mag_reg[1] <= ams_clamp(reg_wdata_i, ams_pkg::AMS_PARAM_LIM); // see R15
        default: ;
      endcase
    end
  end

  // Trims sit apart so that initialising the parameters never touches them
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trq_toff_reg <= ams_pkg::AMS_TRIM_RST;
      trq_tgn_reg  <= ams_pkg::AMS_TRIM_RST;
      spd_toff_reg <= ams_pkg::AMS_TRIM_RST;
      spd_tgn_reg  <= ams_pkg::AMS_TRIM_RST;
    end else if (reg_we_i) begin                                // see R19
      case (reg_addr_i)
        ams_pkg::AMS_A_TRQ_TOFF: trq_toff_reg <= ams_clamp(reg_wdata_i, ams_pkg::AMS_TOFF_LIM); // see R18
        ams_pkg::AMS_A_TRQ_TGN:  trq_tgn_reg  <= ams_clamp(reg_wdata_i, ams_pkg::AMS_TGN_LIM);  // see R18
        ams_pkg::AMS_A_SPD_TOFF: spd_toff_reg <= ams_clamp(reg_wdata_i, ams_pkg::AMS_TOFF_LIM); // see R18
        ams_pkg::AMS_A_SPD_TGN:  spd_tgn_reg  <= ams_clamp(reg_wdata_i, ams_pkg::AMS_TGN_LIM);  // see R18
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel datapath

  logic signed [63:0] out_mv [2];

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic signed [63:0] src_mv;
    logic signed [63:0] trim_mv;
    logic signed [63:0] toff;
    logic signed [63:0] tgn;
    logic               trimmed;
    logic [7:0]         code;

    assign code = sel_reg[c][7:0];                              // see R1

    always_comb begin
      src_mv  = 64'sh0;
      trimmed = 1'b0;
      toff    = 64'sh0;
      tgn     = 64'sh0;
      case (code)
        ams_pkg::AMS_SEL_MOTOR_SPD: begin                       // see R2
          src_mv  = 64'(motor_speed_i);
          trimmed = 1'b1;
          toff    = 64'(signed'(spd_toff_reg));
          tgn     = 64'(signed'(spd_tgn_reg));
        end
        ams_pkg::AMS_SEL_SPD_REF:   src_mv = 64'(speed_ref_i);  // see R3
        ams_pkg::AMS_SEL_CMD_SPD:   src_mv = 64'(cmd_speed_i);  // see R3
        ams_pkg::AMS_SEL_SPD_FF:    src_mv = 64'(speed_ff_i);   // see R3
        ams_pkg::AMS_SEL_TRQ_REF: begin                         // see R4
          src_mv  = 64'(torque_ref_i);
          trimmed = 1'b1;
          toff    = 64'(signed'(trq_toff_reg));
          tgn     = 64'(signed'(trq_tgn_reg));
        end
        ams_pkg::AMS_SEL_TRQ_FF:    src_mv = 64'(torque_ff_i);  // see R4
        ams_pkg::AMS_SEL_POS_DEV:   src_mv = 64'(pos_dev_i) * ams_pkg::AMS_MV_DEV; // see R5
        ams_pkg::AMS_SEL_AMP_DEV:   src_mv = 64'(amp_dev_i) * ams_pkg::AMS_MV_DEV; // see R5
        ams_pkg::AMS_SEL_LOAD_DEV:  src_mv = 64'(load_dev_i) * ams_pkg::AMS_MV_LOAD_DEV; // see R6
        ams_pkg::AMS_SEL_POS_DONE:  src_mv = pos_done_i ? ams_pkg::AMS_MV_FLAG : 64'sh0; // see R7
        ams_pkg::AMS_SEL_DIST_DONE: src_mv = dist_done_i ? ams_pkg::AMS_MV_FLAG : 64'sh0; // see R8
        ams_pkg::AMS_SEL_GAIN:      src_mv = gain2_active_i ? ams_pkg::AMS_MV_GAIN2
                                                            : ams_pkg::AMS_MV_GAIN1; // see R9
        ams_pkg::AMS_SEL_EXT_SPD:   src_mv = 64'(ext_speed_i);  // see R10
        ams_pkg::AMS_SEL_DC_BUS:    src_mv = 64'(dc_bus_i) * ams_pkg::AMS_MV_DC_BUS; // see R11
        // Reserved 06 and unlisted codes give a zero signal
        default:                    src_mv = 64'sh0;            // see R12
      endcase
    end

    // Trim gain as (250 + g)/250, trim offset in 18.9 mV steps
    assign trim_mv = trimmed
      ? (src_mv * (ams_pkg::AMS_TGN_BASE + tgn)) / ams_pkg::AMS_TGN_BASE
        + (toff * ams_pkg::AMS_TOFF_NUM) / ams_pkg::AMS_TOFF_DEN // see R17
      : src_mv;

    // Beyond +/-8 V the analog stage is not linear; code still follows
    assign out_mv[c] = -((trim_mv * 64'(signed'(mag_reg[c]))) / ams_pkg::AMS_MAG_UNITY
                         + 64'(signed'(off_reg[c])) * ams_pkg::AMS_MV_OFF_STEP); // see R13

    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        code_reg[c] <= 16'h0000;
      end else if (ctrl_tick_i) begin                           // see R21
        code_reg[c] <= ams_mv2code(out_mv[c]);                  // see R16, see R20
      end
    end
  end

  assign dac_ch1_o = code_reg[0];
  assign dac_ch2_o = code_reg[1];

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dac_load_o <= 1'b0;
    end else begin
      dac_load_o <= ctrl_tick_i;                                // see R21
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_re_i) begin
      case (reg_addr_i)
        ams_pkg::AMS_A_SEL1:     reg_rdata_o <= sel_reg[0];
        ams_pkg::AMS_A_SEL2:     reg_rdata_o <= sel_reg[1];
        ams_pkg::AMS_A_OFF1:     reg_rdata_o <= off_reg[0];
        ams_pkg::AMS_A_OFF2:     reg_rdata_o <= off_reg[1];
        ams_pkg::AMS_A_MAG1:     reg_rdata_o <= mag_reg[0];
        ams_pkg::AMS_A_MAG2:     reg_rdata_o <= mag_reg[1];
        ams_pkg::AMS_A_TRQ_TOFF: reg_rdata_o <= trq_toff_reg;
        ams_pkg::AMS_A_TRQ_TGN:  reg_rdata_o <= trq_tgn_reg;
        ams_pkg::AMS_A_SPD_TOFF: reg_rdata_o <= spd_toff_reg;
        ams_pkg::AMS_A_SPD_TGN:  reg_rdata_o <= spd_tgn_reg;
        ams_pkg::AMS_A_CODE1:    reg_rdata_o <= code_reg[0];
        ams_pkg::AMS_A_CODE2:    reg_rdata_o <= code_reg[1];
        default:                 reg_rdata_o <= 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  logic neutral1;
  assign neutral1 = (mag_reg[0] == ams_pkg::AMS_MAG_RST) && (off_reg[0] == 16'h0000);

  sequence s_tick_sel1(logic [7:0] sc);
    ctrl_tick_i && (sel_reg[0][7:0] == sc) && neutral1;
  endsequence

  property p_load_follows_tick;
    ctrl_tick_i |=> dac_load_o ##1 (!dac_load_o || $past(ctrl_tick_i));
  endproperty
  a_load_follows_tick: assert property (p_load_follows_tick) // see R21
    else $error("load pulse does not follow control tick");

  property p_hold_between_ticks;
    !ctrl_tick_i |=> $stable(dac_ch1_o) && $stable(dac_ch2_o);
  endproperty
  a_hold_between_ticks: assert property (p_hold_between_ticks) // see R21
    else $error("codes changed without a control tick");

  property p_offset_clamp;
    reg_we_i && (reg_addr_i == ams_pkg::AMS_A_OFF1) && !init_w
      && (signed'(reg_wdata_i) > ams_pkg::AMS_PARAM_LIM)
      |=> off_reg[0] == ams_pkg::AMS_PARAM_LIM;
  endproperty
  a_offset_clamp: assert property (p_offset_clamp) // see R14
    else $error("offset not clamped to its upper limit");

  property p_mag_clamp;
    reg_we_i && (reg_addr_i == ams_pkg::AMS_A_MAG2) && !init_w
      && (signed'(reg_wdata_i) < -ams_pkg::AMS_PARAM_LIM)
      |=> mag_reg[1] == 16'(-ams_pkg::AMS_PARAM_LIM);
  endproperty
  a_mag_clamp: assert property (p_mag_clamp) // see R15
    else $error("magnification not clamped to its lower limit");

  property p_init_keeps_trims;
    init_w |=> (mag_reg[0] == ams_pkg::AMS_MAG_RST) && (sel_reg[0] == ams_pkg::AMS_SEL1_RST)
               && $stable(trq_toff_reg) && $stable(spd_tgn_reg);
  endproperty
  a_init_keeps_trims: assert property (p_init_keeps_trims) // see R19
    else $error("initialisation disturbed trims or missed defaults");

  property p_pos_done_5v;
    s_tick_sel1(ams_pkg::AMS_SEL_POS_DONE) and pos_done_i
      |=> dac_ch1_o == ams_mv2code(-ams_pkg::AMS_MV_FLAG);
  endproperty
  a_pos_done_5v: assert property (p_pos_done_5v) // see R7
    else $error("positioning completion does not give -5 V code");

  // Reserved 06 and every code above the last listed one carry no signal
  property p_reserved_zero;
    ctrl_tick_i && neutral1
      && ((sel_reg[0][7:0] == ams_pkg::AMS_SEL_RESERVED)
          || (sel_reg[0][7:0] > ams_pkg::AMS_SEL_DC_BUS))
      |=> dac_ch1_o == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // see R12
    else $error("reserved selection gives nonzero code");

  property p_gain_level;
    s_tick_sel1(ams_pkg::AMS_SEL_GAIN)
      |=> dac_ch1_o == ams_mv2code($past(gain2_active_i) ? -ams_pkg::AMS_MV_GAIN2
                                                         : -ams_pkg::AMS_MV_GAIN1);
  endproperty
  a_gain_level: assert property (p_gain_level) // see R9
    else $error("active gain level wrong");

  // From +10 V on the scaled value no longer fits the positive code range
  property p_saturate;
    ctrl_tick_i && (out_mv[0] >= 64'sh0000_0000_0000_2710) |=> dac_ch1_o == 16'h7FFF;
  endproperty
  a_saturate: assert property (p_saturate) // see R20
    else $error("large result not saturated to full scale");

  property p_dev_scale;
    s_tick_sel1(ams_pkg::AMS_SEL_POS_DEV)
      |=> dac_ch1_o == ams_mv2code(-(64'($past(pos_dev_i)) * ams_pkg::AMS_MV_DEV));
  endproperty
  a_dev_scale: assert property (p_dev_scale) // see R5
    else $error("position deviation scale wrong");

endmodule : ams_monitor

`default_nettype wire

//--- sim/ams_meter.sv
/*
  Measuring instrument model on the two monitor outputs.
  Assumes the codes are valid in the cycle that the update pulse is high.
*/
`timescale 1ns/1ps
`default_nettype none
module ams_meter (
  input  wire logic        clk_i,   // 50 MHz clock
  input  wire logic        load_i,  // Codes updated pulse
  input  wire logic [15:0] ch1_i,   // Channel one code
  input  wire logic [15:0] ch2_i    // Channel two code
);
  logic [15:0] ch1_seen;
  logic [15:0] ch2_seen;
  // Samples only on the pulse, so a code that lands late is missed
  always_ff @(posedge clk_i) begin
    if (load_i) begin
      ch1_seen <= ch1_i;
      ch2_seen <= ch2_i;
    end
  end
endmodule : ams_meter
`default_nettype wire

//--- sim/tb.sv
/*
  Self-checking bench for the analog monitor block.
  Assumes the plain register port and one control tick per update.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic               clk_i = 1'b0;
  logic               reset_n_i = 1'b0;
  logic [3:0]         reg_addr_i = 4'h0;
  logic [15:0]        reg_wdata_i = 16'h0000;
  logic               reg_we_i = 1'b0, reg_re_i = 1'b0, ctrl_tick_i = 1'b0;
  logic signed [31:0] spd = 1000, sref = 1100, cspd = 1200, sff = 1300, espd = 1400;
  logic signed [31:0] tref = 500, tff = 600, pdev = 20, adev = 21, ldev = 30, dcb = 300;
  logic               pdone = 1'b1, ddone = 1'b0, g2 = 1'b1, dl;
  logic [15:0]        rd_d, c1, c2;
  int                 num_errors = 0, num_checks = 0;
  logic [7:0]         codes [14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07,
                                     8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h10};
  logic [15:0]        rst [6] = '{16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h0064};

  always #10 clk_i = ~clk_i;

  ams_monitor i_ams_monitor (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(rd_d),
    .ctrl_tick_i(ctrl_tick_i), .motor_speed_i(spd), .speed_ref_i(sref), .cmd_speed_i(cspd),
    .speed_ff_i(sff), .ext_speed_i(espd), .torque_ref_i(tref), .torque_ff_i(tff),
    .pos_dev_i(pdev), .amp_dev_i(adev), .load_dev_i(ldev), .dc_bus_i(dcb),
    .pos_done_i(pdone), .dist_done_i(ddone), .gain2_active_i(g2), .dac_ch1_o(c1),
    .dac_ch2_o(c2), .dac_load_o(dl));
  ams_meter i_ams_meter (.clk_i(clk_i), .load_i(dl), .ch1_i(c1), .ch2_i(c2));

  ////////////////////////////////////////////////////////////////////////////
  function automatic longint sig_mv(input logic [7:0] c);
    case (c)
      8'h00: return spd;
      8'h01: return sref;
      8'h02: return tref;
      8'h03: return pdev * 50;
      8'h04: return adev * 50;
      8'h05: return cspd;
      8'h07: return ldev * 10;
      8'h08: return pdone ? 5000 : 0;
      8'h09: return sff;
      8'h0A: return tff;
      8'h0B: return g2 ? 2000 : 1000;
      8'h0C: return ddone ? 5000 : 0;
      8'h0D: return espd;
      8'h10: return dcb * 10;
      default: return 0;
    endcase
  endfunction : sig_mv

  function automatic logic [15:0] exp_code(input longint s, input longint mag, input longint off);
    longint mv;
    mv = -((s * mag) / 100 + off * 100);
    mv = (mv * ams_pkg::AMS_CODE_NUM) >>> ams_pkg::AMS_CODE_SHIFT;
    if (mv > 32767) mv = 32767;
    if (mv < -32768) mv = -32768;
    return mv[15:0];
  endfunction : exp_code

  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i) {reg_we_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
    @(posedge clk_i) reg_we_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_i) {reg_re_i, reg_addr_i} <= {1'b1, a};
    @(posedge clk_i) reg_re_i <= 1'b0;
    #1 chk("reg_rdata_o", rd_d, exp);
  endtask : rd

  task automatic tick(input logic [15:0] e1, input logic [15:0] e2);
    @(posedge clk_i) ctrl_tick_i <= 1'b1;
    @(posedge clk_i) ctrl_tick_i <= 1'b0;
    #1 chk("dac_load_o", {15'h0000, dl}, 16'h0001);
    chk("dac_ch1_o", c1, e1);
    chk("dac_ch2_o", c2, e2);
    @(posedge clk_i) #1 chk("dac_load_o", {15'h0000, dl}, 16'h0000);
    chk("meter ch1", i_ams_meter.ch1_seen, e1);
    chk("meter ch2", i_ams_meter.ch2_seen, e2);
  endtask : tick

  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000 num_errors++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (int a = 0; a < 6; a++) rd(4'(a), rst[a]);
    rd(4'hD, 16'h0000);
    $display("test reset values done");
    wr(ams_pkg::AMS_A_MAG2, 16'hFF9C);
    wr(ams_pkg::AMS_A_OFF2, 16'h000A);
    // Second pass flips the flag inputs to see both output levels
    for (int p = 0; p < 2; p++) begin
      @(posedge clk_i) {pdone, ddone, g2} <= p ? 3'b010 : 3'b101;
      // Code 06 is left out on purpose; it is reserved
      for (int i = 0; i < 14; i++) begin
        wr(ams_pkg::AMS_A_SEL1, {8'h00, codes[i]});
        wr(ams_pkg::AMS_A_SEL2, {8'h00, codes[i]});
        tick(exp_code(sig_mv(codes[i]), 100, 0), exp_code(sig_mv(codes[i]), -100, 10));
      end
    end
    $display("test selection codes done");
    wr(ams_pkg::AMS_A_OFF1, 16'h4E20);
    rd(ams_pkg::AMS_A_OFF1, 16'h2710);
    wr(ams_pkg::AMS_A_OFF1, 16'h0000);
    wr(ams_pkg::AMS_A_SEL1, 16'h0000);
    wr(ams_pkg::AMS_A_MAG1, 16'h03E8);
    tick(16'h8000, exp_code(sig_mv(8'h10), -100, 10));
    wr(ams_pkg::AMS_A_MAG1, 16'hFC18);
    tick(16'h7FFF, exp_code(sig_mv(8'h10), -100, 10));
    $display("test scaling and saturation done");
    wr(ams_pkg::AMS_A_MAG1, 16'h0064);
    // Upper bits are ignored; low code 20 is unlisted and carries no signal
    wr(ams_pkg::AMS_A_SEL1, 16'h1120);
    tick(16'h0000, exp_code(sig_mv(8'h10), -100, 10));
    wr(ams_pkg::AMS_A_SEL1, 16'h0002);
    wr(ams_pkg::AMS_A_SEL2, 16'h0000);
    wr(ams_pkg::AMS_A_TRQ_TOFF, 16'h000A);
    wr(ams_pkg::AMS_A_TRQ_TGN, 16'h007D);
    wr(ams_pkg::AMS_A_SPD_TOFF, 16'hFFF6);
    wr(ams_pkg::AMS_A_SPD_TGN, 16'hFF83);
    tick(exp_code(500 * 375 / 250 + 189, 100, 0), exp_code(1000 * 125 / 250 - 189, -100, 10));
    wr(ams_pkg::AMS_A_MAG2, 16'h8000);
    rd(ams_pkg::AMS_A_MAG2, 16'hD8F0);
    wr(ams_pkg::AMS_A_CTRL, 16'h0001);
    rd(ams_pkg::AMS_A_SEL1, 16'h0002);
    rd(ams_pkg::AMS_A_MAG2, 16'h0064);
    rd(ams_pkg::AMS_A_OFF2, 16'h0000);
    rd(ams_pkg::AMS_A_TRQ_TOFF, 16'h000A);
    rd(ams_pkg::AMS_A_SPD_TGN, 16'hFF83);
    $display("test trims and init done");
    stop_test();
  end
endmodule : tb
`default_nettype wire
